//--- inc/rpo_pkg.sv
package rpo_pkg;
  // bank geometry
  localparam int MACRO_CELLS = 24;
  localparam int GROUP_SIZE = 12;
  localparam int TOTAL_REGS = 48;
  // power-up reset interval in ns, typical and longest
  localparam int PUR_TYP_NS = 600;
  localparam int PUR_MAX_NS = 1000;
  localparam int CLK_PERIOD_NS = 8;
  // longest time rounds down
  localparam int PUR_CYCLES = PUR_MAX_NS / CLK_PERIOD_NS;
  // register map offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_BANK1 = 8'h08;
  localparam logic [7:0] OFS_BANK2 = 8'h0C;
  localparam logic [7:0] OFS_POL = 8'h10;
  // control field positions
  localparam int CTRL_FUSE_BIT = 0;
  // status field positions
  localparam int ST_PRELOAD_BIT = 0;
  localparam int ST_OBSERVE_BIT = 1;
  localparam int ST_FUSE_BIT = 2;
  localparam int ST_PUR_BIT = 3;
  // reset values
  localparam logic [23:0] POL_RESET = 24'h00_0000;
  // group select codes {parity, pair}
  typedef enum logic [1:0] {
    RPO_EVEN_FIRST = 2'b00,
    RPO_EVEN_SECOND = 2'b01,
    RPO_ODD_FIRST = 2'b10,
    RPO_ODD_SECOND = 2'b11
  } rpo_group_type;
endpackage

//--- inc/rpo_load_if.sv
`timescale 1ns/1ps
interface rpo_load_if;
  logic strobe;
  logic [1:0] group;
  logic [11:0] data;
  logic [23:0] hit;
  logic [11:0] value;
  modport ctl (output strobe, output group, output data, input hit,
               input value);
  modport dec (input strobe, input group, input data, output hit,
               output value);
endinterface

//--- verilog/rpo_group_dec.sv
`timescale 1ns/1ps
module rpo_group_dec (
  // load request carrier
  rpo_load_if.dec ld,
  // which bank the decode is for
  input wire logic for_q2
);
  logic [1:0] sel;
  assign sel = ld.group;
  // cell hit on every second cell, 12 in all, for the addressed group
  always_comb begin
    ld.hit = '0;
    for (int i = 0; i < rpo_pkg::GROUP_SIZE; i++) begin
      if (ld.strobe && (sel[0] == for_q2)) begin
        ld.hit[2*i + int'(sel[1])] = 1'b1;
      end
    end
  end
  assign ld.value = ld.data;
endmodule

//--- verilog/rpo_sync2.sv
`timescale 1ns/1ps
module rpo_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // async in, synced out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  // two-flop synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q <= '0;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

//--- verilog/rpo_top.sv
`timescale 1ns/1ps
// Function
// - each register loadable high or low without the functional clock
// - odd pin high sets selected register, low clears it
// - forced value ignores polarity and configuration bits
// - load strobe pulse loads one group of 12 registers together
// - pair and parity selects pick the group; others unchanged
// - observe mode drives second-register bank onto enabled outputs
// - after power-up all registers clear low
// - outputs after reset follow polarity applied to cleared value
// - programmed fuse makes outputs read programmed during verify
// - programmed fuse disables preload and observe modes
// - fuse acts immediately; programmer sets it last
// - each macrocell has first and second register, 48 total
module rpo_top #(
  parameter int CELLS = rpo_pkg::MACRO_CELLS,
  parameter int PUR_COUNT = rpo_pkg::PUR_CYCLES
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // test pins (asynchronous)
  input wire logic special_mode_lead,
  input wire logic observe_mode_lead,
  input wire logic load_strobe,
  input wire logic pair_select,
  input wire logic parity_select,
  input wire logic verify_read,
  input wire logic [11:0] odd_io_in,
  // functional next-state from the array
  input wire logic func_clk_en,
  input wire logic [23:0] func_d1,
  input wire logic [23:0] func_d2,
  input wire logic [23:0] func_oe,
  // output pins
  output logic [23:0] io_out,
  output logic [23:0] io_oe
);
  logic [23:0] first_macrocell_register_r;
  logic [23:0] second_macrocell_register_r;
  logic [23:0] pol_r;
  logic fuse_r;
  logic [$clog2(PUR_COUNT+1)-1:0] pur_cnt_r;
  logic pur_busy;
  logic [17:0] pin_s;
  logic strobe_d_r;
  logic preload_mode;
  logic observe_mode;
  logic load_pulse;
  logic [23:0] b1_hit;
  logic [23:0] b2_hit;
  logic [11:0] b1_val;
  logic [11:0] b2_val;
  logic [23:0] b1_nxt;
  logic [23:0] b2_nxt;
  logic [23:0] shown;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  // pins pass two flops first
  rpo_sync2 #(.W(18)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(clk_en),
    .d({special_mode_lead, observe_mode_lead, load_strobe, pair_select,
        parity_select, verify_read, odd_io_in}),
    .q(pin_s)
  );

  // mode qualification, fuse blocks both
  assign preload_mode = pin_s[17] && !fuse_r;
  assign observe_mode = pin_s[16] && !fuse_r;

  // rising edge of load strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_d_r <= 1'b0;
    end else if (clk_en) begin
      strobe_d_r <= pin_s[15];
    end
  end
  assign load_pulse = preload_mode && pin_s[15] && !strobe_d_r;

  // group decode per bank
  rpo_load_if ld1 ();
  rpo_load_if ld2 ();
  assign ld1.strobe = load_pulse;
  assign ld1.group = {pin_s[13], pin_s[14]};
  assign ld1.data = pin_s[11:0];
  assign ld2.strobe = load_pulse;
  assign ld2.group = {pin_s[13], pin_s[14]};
  assign ld2.data = pin_s[11:0];
  assign b1_hit = ld1.hit;
  assign b2_hit = ld2.hit;
  assign b1_val = ld1.value;
  assign b2_val = ld2.value;

  rpo_group_dec u_dec1 (
    .ld(ld1.dec),
    .for_q2(1'b0)
  );

  rpo_group_dec u_dec2 (
    .ld(ld2.dec),
    .for_q2(1'b1)
  );

  // power-up reset interval counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pur_cnt_r <= '0;
    end else if (clk_en && pur_busy) begin
      pur_cnt_r <= pur_cnt_r + 1'b1;
    end
  end
  assign pur_busy = (pur_cnt_r < ($clog2(PUR_COUNT+1))'(PUR_COUNT));

  // next register values: preload overrides functional clocking
  genvar g;
  generate
    for (g = 0; g < CELLS; g++) begin : g_cell
      localparam int K = g / 2;
      always_comb begin
        b1_nxt[g] = first_macrocell_register_r[g];
        b2_nxt[g] = second_macrocell_register_r[g];
        if (b1_hit[g]) begin
          b1_nxt[g] = b1_val[K];
        end else if (!preload_mode && func_clk_en && !pur_busy) begin
          b1_nxt[g] = func_d1[g];
        end
        if (b2_hit[g]) begin
          b2_nxt[g] = b2_val[K];
        end else if (!preload_mode && func_clk_en && !pur_busy) begin
          b2_nxt[g] = func_d2[g];
        end
      end
    end
  endgenerate

  // first register bank, cleared at power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_macrocell_register_r <= '0;
    end else if (clk_en) begin
      first_macrocell_register_r <= b1_nxt;
    end
  end

  // second register bank, cleared at power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_macrocell_register_r <= '0;
    end else if (clk_en) begin
      second_macrocell_register_r <= b2_nxt;
    end
  end

  // apb decode, zero wait states
  assign addr_ok = (paddr == rpo_pkg::OFS_CTRL) ||
                   (paddr == rpo_pkg::OFS_STATUS) ||
                   (paddr == rpo_pkg::OFS_BANK1) ||
                   (paddr == rpo_pkg::OFS_BANK2) ||
                   (paddr == rpo_pkg::OFS_POL);
  assign wr_en = psel && penable && pwrite && clk_en;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // security fuse, one-time set, effective at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_r <= 1'b0;
    end else if (wr_en && paddr == rpo_pkg::OFS_CTRL &&
                 pwdata[rpo_pkg::CTRL_FUSE_BIT]) begin
      fuse_r <= 1'b1;
    end
  end

  // output polarity configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_r <= rpo_pkg::POL_RESET;
    end else if (wr_en && paddr == rpo_pkg::OFS_POL) begin
      pol_r <= pwdata[23:0];
    end
  end

  // read data mux, fuse hides both banks whatever verify does
  always_comb begin
    prdata = '0;
    if (rd_en) begin
      case (paddr)
        rpo_pkg::OFS_CTRL: prdata[rpo_pkg::CTRL_FUSE_BIT] = fuse_r;
        rpo_pkg::OFS_STATUS: begin
          prdata[rpo_pkg::ST_PRELOAD_BIT] = preload_mode;
          prdata[rpo_pkg::ST_OBSERVE_BIT] = observe_mode;
          prdata[rpo_pkg::ST_FUSE_BIT] = fuse_r;
          prdata[rpo_pkg::ST_PUR_BIT] = pur_busy;
        end
        rpo_pkg::OFS_BANK1: prdata[23:0] = fuse_r ? '1 :
          first_macrocell_register_r;
        rpo_pkg::OFS_BANK2: prdata[23:0] = fuse_r ? '1 :
          second_macrocell_register_r;
        rpo_pkg::OFS_POL: prdata[23:0] = pol_r;
        default: prdata = '0;
      endcase
    end
  end

  // pin view: observe picks second bank as is, else first bank with polarity applied
  always_comb begin
    if (observe_mode) begin
      shown = second_macrocell_register_r;
    end else begin
      shown = first_macrocell_register_r ^ pol_r;
    end
  end

  // output pins registered; verify with fuse reads programmed (all high)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_out <= '0;
      io_oe <= '0;
    end else if (clk_en) begin
      io_oe <= func_oe;
      if (pin_s[12] && fuse_r) begin
        io_out <= '1;
      end else begin
        io_out <= shown;
      end
    end
  end
endmodule

//--- tb/rpo_top_props.sv
`timescale 1ns/1ps
module rpo_top_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic verify_read,
  input wire logic [23:0] func_oe,
  input wire logic [23:0] io_out,
  input wire logic [23:0] io_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic fuse_r;
  logic rd_acc;
  // fuse copy taken from apb writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      fuse_r <= 1'b0;
    else if (psel && penable && pwrite && clk_en && paddr == 8'h00 &&
             pwdata[0])
      fuse_r <= 1'b1;
  end
  assign rd_acc = psel && penable && !pwrite;
  // verify held through the pin sync while fused
  sequence verify_held;
    (verify_read && clk_en)[*3] ##0 fuse_r;
  endsequence
  a_fuse_verify: assert property (
    verify_held |=> io_out == 24'hff_ffff)
    else $error("outputs not high during fused verify");
  a_fuse_hides: assert property (
    rd_acc && paddr == 8'h0c && fuse_r |-> prdata[23:0] == 24'hff_ffff)
    else $error("second bank not hidden");
  a_fuse_blocks: assert property (
    rd_acc && paddr == 8'h04 && fuse_r |-> prdata[2:0] == 3'b100)
    else $error("test modes not blocked by fuse");
  a_reset_clear: assert property ($rose(presetn)
    |-> io_out == 24'h00_0000 && io_oe == 24'h00_0000)
    else $error("outputs not cleared by reset");
  a_oe_follows: assert property (clk_en && presetn
    |=> io_oe == $past(func_oe)) else $error("output enable not one cycle late");
  a_ready_high: assert property (psel |-> pready)
    else $error("apb wait state seen");
  a_unmapped_err: assert property (psel && penable |-> pslverr ==
    !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}))
    else $error("slave error does not match address map");
  a_idle_rdata: assert property (!psel || (rd_acc && pslverr)
    |-> prdata == 32'h0000_0000) else $error("read data not zero");
endmodule
bind rpo_top rpo_top_props i_props (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .verify_read(verify_read), .func_oe(func_oe),
  .io_out(io_out), .io_oe(io_oe));

//--- tb/rpo_tester.sv
`timescale 1ns/1ps
module rpo_tester (
  // clock
  input wire logic pclk,
  // test pins towards the device
  output logic special_mode_lead,
  output logic observe_mode_lead,
  output logic load_strobe,
  output logic pair_select,
  output logic parity_select,
  output logic verify_read,
  output logic [11:0] odd_io_in
);
  // all leads idle at start
  initial begin
    {special_mode_lead, observe_mode_lead, load_strobe} = 3'b000;
    {pair_select, parity_select, verify_read, odd_io_in} = 15'h0000;
  end
  // one forced-load cycle, hold sets the pace
  task automatic preload(input logic [1:0] grp, input logic [11:0] d,
                         input int hold);
    @(posedge pclk);
    special_mode_lead <= 1'b1;
    {parity_select, pair_select} <= grp;
    odd_io_in <= d;
    repeat (hold) @(posedge pclk);
    load_strobe <= 1'b1;
    repeat (hold) @(posedge pclk);
    load_strobe <= 1'b0;
    repeat (hold) @(posedge pclk);
    special_mode_lead <= 1'b0;
    odd_io_in <= ~d; // released pins show no stale data
  endtask
  // observe and verify leads
  task automatic lead(input logic obs, input logic ver);
    @(posedge pclk);
    observe_mode_lead <= obs;
    verify_read <= ver;
  endtask
endmodule

//--- tb/rpo_top_test.sv
`timescale 1ns/1ps
module rpo_top_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, func_clk_en;
  logic special_mode_lead, observe_mode_lead, load_strobe;
  logic pair_select, parity_select, verify_read;
  logic [7:0] paddr;
  logic [11:0] odd_io_in;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] func_d1, func_d2, func_oe, io_out, io_oe, exp1, exp2, pol;
  int miscompares = 0;
  int checked = 0;
  // 125 MHz clock
  always #4 pclk = ~pclk;
  rpo_top #(.PUR_COUNT(4)) i_rpo_top (.pclk, .presetn, .clk_en,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .special_mode_lead, .observe_mode_lead, .load_strobe, .pair_select,
    .parity_select, .verify_read, .odd_io_in, .func_clk_en, .func_d1,
    .func_d2, .func_oe, .io_out, .io_oe);
  rpo_tester i_rpo_tester (.pclk, .special_mode_lead, .observe_mode_lead,
    .load_strobe, .pair_select, .parity_select, .verify_read, .odd_io_in);
  // random output enables every cycle
  always @(posedge pclk) func_oe <= 24'($urandom);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task tally_and_finish;
    if (miscompares == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    logic [11:0] d;
    {psel, penable, pwrite, func_clk_en, paddr, pwdata} = 44'h0;
    {func_d1, func_d2, exp1, exp2, pol} = 120'h0;
    void'($urandom(32'h0000_ad72));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(8'h04, 32'h0000_0008);
    repeat (8) @(posedge pclk); // clock terms quiet
    rdchk(8'h08, 32'h0000_0000);
    rdchk(8'h0c, 32'h0000_0000);
    chk({8'h00, io_out}, 32'h0000_0000);
    rdchk(8'h14, 32'h0000_0000);
    pol = 24'($urandom);
    apb(1'b1, 8'h10, {8'h00, pol});
    // each group twice with random data, paced by 3 to 5 cycles
    for (int k = 0; k < 8; k++) begin
      d = 12'($urandom);
      i_rpo_tester.preload(2'(k), d, 3 + k % 3);
      for (int i = 0; i < 12; i++)
        if (k[0]) exp2[2*i+k[1]] = d[i];
        else exp1[2*i+k[1]] = d[i];
      rdchk(8'h08, {8'h00, exp1});
      rdchk(8'h0c, {8'h00, exp2});
    end
    chk({8'h00, io_out}, {8'h00, exp1 ^ pol});
    i_rpo_tester.lead(1'b1, 1'b0);
    repeat (6) @(posedge pclk);
    chk({8'h00, io_out}, {8'h00, exp2});
    i_rpo_tester.lead(1'b0, 1'b0);
    // functional load outside test modes
    exp1 = 24'($urandom);
    exp2 = 24'($urandom);
    func_d1 <= exp1;
    func_d2 <= exp2;
    func_clk_en <= 1'b1;
    repeat (4) @(posedge pclk);
    func_clk_en <= 1'b0;
    rdchk(8'h08, {8'h00, exp1});
    rdchk(8'h0c, {8'h00, exp2});
    // clock enable low freezes the banks
    clk_en <= 1'b0;
    func_d1 <= ~exp1;
    func_clk_en <= 1'b1;
    repeat (4) @(posedge pclk);
    clk_en <= 1'b1;
    func_clk_en <= 1'b0;
    rdchk(8'h08, {8'h00, exp1});
    // fuse set last, then test modes refused
    apb(1'b1, 8'h00, 32'h0000_0001);
    rdchk(8'h04, 32'h0000_0004);
    for (int i = 0; i < 12; i++)
      d[i] = ~exp1[2*i];
    i_rpo_tester.preload(2'b00, d, 3);
    chk({8'h00, io_out}, {8'h00, exp1 ^ pol});
    rdchk(8'h08, 32'h00ff_ffff);
    i_rpo_tester.lead(1'b1, 1'b1);
    repeat (6) @(posedge pclk);
    chk({8'h00, io_out}, 32'h00ff_ffff);
    rdchk(8'h04, 32'h0000_0004);
    rdchk(8'h0c, 32'h00ff_ffff);
    tally_and_finish;
  end
  // hang guard
  initial begin
    #100000;
    miscompares++;
    tally_and_finish;
  end
endmodule
